// File: design/smctm_phase_counter.sv
/*
  Elapsed-cycle counter for one bus phase, with its next value exposed.
  Assumes the owner clears it on entry to every phase.
*/
`timescale 1ns/10ps
module smctm_phase_counter
  #(parameter int W = 4)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic clear,
  // count
  output logic [W-1:0] count,
  output logic [W-1:0] countNext
);

  logic [W-1:0] count_q;

  // saturates so a stuck phase never wraps into a short one
  always_comb
  begin
    if (clear)
      countNext = '0;
    else if (&count_q)
      countNext = count_q;
    else
      countNext = count_q + W'(1);
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      count_q <= '0;
    else
      count_q <= countNext;
  end

  assign count = count_q;

endmodule

// File: design/smctm_pkg.sv
/*
  Shared constants for the static memory timing and mode block: register
  offsets, field positions, reset values, region start bytes and states.
  Assumes a single 25 MHz clock; all timing counts are in those clocks.
*/
// Behaviour
// - turnaround length 1-7 clocks, bits 19-17
// - write strobe width 1-7 clocks, bits 13-11
// - read strobe delay 1-7 clocks, bits 10-8
// - write cycle 3-15 clocks, bits 7-4
// - read cycle 2-15 clocks, bits 3-0
// - region zero start byte reads 0x60
// - region one start byte reads 0x61
// - mode bit 11 enables address latch strobe
// - burst code 000 single, 001 four beats
// - width code 01 means 16-bit bus
package smctm_pkg;

  localparam int REG_AW = 8;

  // register offsets
  localparam logic [7:0] OFF_TIMING3 = 8'h00;
  localparam logic [7:0] OFF_MODE0 = 8'h04;
  localparam logic [7:0] OFF_MODE1 = 8'h08;
  localparam logic [7:0] OFF_SET_TIMING = 8'h0c;
  localparam logic [7:0] OFF_SET_MODE = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // timing field positions
  localparam int TR_LSB = 17;
  localparam int WP_LSB = 11;
  localparam int CEOE_LSB = 8;
  localparam int WC_LSB = 4;
  localparam int RC_LSB = 0;

  // mode field positions
  localparam int MATCH_LSB = 24;
  localparam int FILL_LSB = 16;
  localparam int ADV_BIT = 11;
  localparam int BL_LSB = 3;
  localparam int MW_LSB = 0;

  // timing reset values
  localparam logic [2:0] TR_RST = 3'h1;
  localparam logic [2:0] WP_RST = 3'h6;
  localparam logic [2:0] CEOE_RST = 3'h3;
  localparam logic [3:0] WC_RST = 4'hc;
  localparam logic [3:0] RC_RST = 4'h4;

  // smallest legal codes, lower codes are raised to these; WE_START is the first write strobe phase
  localparam logic [3:0] TR_MIN = 4'h1;
  localparam logic [3:0] WP_MIN = 4'h1;
  localparam logic [3:0] CEOE_MIN = 4'h1;
  localparam logic [3:0] WC_MIN = 4'h3;
  localparam logic [3:0] RC_MIN = 4'h2;
  localparam logic [3:0] WE_START = 4'h1;

  // mode values
  localparam logic [7:0] START_R0 = 8'h60;
  localparam logic [7:0] START_R1 = 8'h61;
  localparam logic [7:0] START_R3 = 8'h63;
  localparam logic [7:0] MODE_FILL = 8'hff;
  localparam logic ADV_RST = 1'b1;
  localparam logic [2:0] BL_RST = 3'h0;
  localparam logic [2:0] BL_FOUR = 3'h1;
  localparam logic [1:0] MW_16 = 2'h1;
  localparam logic [1:0] BEAT_LAST = 2'h3;

  // command and status bits
  localparam int CMD_TIM_BIT = 0;
  localparam int CMD_M0_BIT = 1;
  localparam int CMD_M1_BIT = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_ERR_BIT = 1;
  localparam int ST_PEND_BIT = 2;

  typedef enum logic [2:0] {
    S_IDLE,
    S_LATCH,
    S_READ,
    S_WRITE,
    S_TURN
  } smctm_state_type;

endpackage

// File: design/smctm_region_mode.sv
/*
  Operating mode of one chip-select region: fixed start byte, address
  latch use, read burst code and bus width code, plus the address match.
  Assumes the owner loads new settings only while the bus is idle.
*/
`timescale 1ns/10ps
module smctm_region_mode
  import smctm_pkg::*;
  #(parameter logic [7:0] START = START_R0)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // settings load
  input wire logic load,
  input wire logic [31:0] loadWord,
  // address match
  input wire logic [7:0] addrHigh,
  output logic hit,
  // settings
  output logic adv,
  output logic [2:0] burstCode,
  output logic [1:0] widthCode,
  output logic [31:0] modeWord
);

  logic adv_q, adv_d;
  logic [2:0] bl_q, bl_d;
  logic [1:0] mw_q, mw_d;

  always_comb
  begin
    adv_d = adv_q;
    bl_d = bl_q;
    mw_d = mw_q;
    if (load)
    begin
      adv_d = loadWord[ADV_BIT];
      bl_d = loadWord[BL_LSB +: 3];
      mw_d = loadWord[MW_LSB +: 2];
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      adv_q <= ADV_RST;
      bl_q <= BL_RST;
      mw_q <= MW_16;
    end
    else
    begin
      adv_q <= adv_d;
      bl_q <= bl_d;
      mw_q <= mw_d;
    end
  end

  assign hit = (addrHigh == START);
  assign adv = adv_q;
  assign burstCode = bl_q;
  assign widthCode = mw_q;
  // start byte is wired, so software can never move the region
  assign modeWord = (32'(START) << MATCH_LSB)
    | (32'(MODE_FILL) << FILL_LSB)
    | (32'(adv_q) << ADV_BIT)
    | (32'(bl_q) << BL_LSB)
    | (32'(mw_q) << MW_LSB);

endmodule

// File: design/smctm_top.sv
/*
  Static memory controller slice: access timing of region three, mode of
  regions zero and one, and the engine that runs asynchronous 16-bit
  read and write cycles on the external pins.
  Assumes a plain register port and a request port held until acknowledged.
*/
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module smctm_top
  import smctm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdata,
  // request port
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [31:0] memAddr,
  input wire logic [15:0] memWdata,
  output logic memAck,
  output logic memErr,
  output logic memRdValid,
  output logic [15:0] memRdata,
  output logic memDone,
  // external memory pins
  output logic chipSelZeroN,
  output logic chipSelOneN,
  output logic chipSelThreeN,
  output logic addrLatch,
  output logic outEnN,
  output logic writeEnN,
  output logic [22:0] extAddr,
  input wire logic [15:0] extDataIn,
  output logic [15:0] extDataOut,
  output logic extDataOeN
);

  smctm_state_type state_q, state_d;
  logic [2:0] sel_q, sel_d;
  logic [22:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic write_q, write_d;
  logic [1:0] beat_q, beat_d;
  logic phClear;
  logic [3:0] phCount, phNext;
  logic memAck_d, memErr_d, memRdValid_d, memDone_d;
  logic [15:0] memRdata_d;
  logic memAck_q;
  logic [15:0] memRdata_q;
  logic applyNow;
  logic [2:0] trQ, trD, wpQ, wpD, ceoeQ, ceoeD;
  logic [3:0] wcQ, wcD, rcQ, rcD;
  logic [31:0] setTim_q, setTim_d, setMode_q, setMode_d;
  logic [2:0] pend_q, pend_d;
  logic err_q, err_d;
  logic [31:0] regRdata_d;
  logic csZ_d, csO_d, csT_d, ale_d, oeN_d, weN_d, drvN_d;
  logic hit0, hit1, hit3, adv0, adv1, reqAdv, curAdv;
  logic [2:0] bl0, bl1, curBl;
  logic [31:0] mode0Word, mode1Word, timingWord;
  logic [3:0] trE, wpE, ceoeE, wcE, rcE, weLim;
  logic [3:0] weRun_q;

  function automatic logic [3:0] atLeast(input logic [3:0] v,
                                         input logic [3:0] lo);
    atLeast = (v < lo) ? lo : v;
  endfunction

  smctm_phase_counter #(.W(4)) u_phase (
    .clk(clk),
    .reset(reset),
    .clear(phClear),
    .count(phCount),
    .countNext(phNext)
  );

  smctm_region_mode #(.START(START_R0)) u_mode0 (
    .clk(clk),
    .reset(reset),
    .load(applyNow && pend_q[CMD_M0_BIT]),
    .loadWord(setMode_q),
    .addrHigh(memAddr[31:24]),
    .hit(hit0),
    .adv(adv0),
    .burstCode(bl0),
    .widthCode(),
    .modeWord(mode0Word)
  );

  smctm_region_mode #(.START(START_R1)) u_mode1 (
    .clk(clk),
    .reset(reset),
    .load(applyNow && pend_q[CMD_M1_BIT]),
    .loadWord(setMode_q),
    .addrHigh(memAddr[31:24]),
    .hit(hit1),
    .adv(adv1),
    .burstCode(bl1),
    .widthCode(),
    .modeWord(mode1Word)
  );

  // region three has no mode register here, so it runs with reset modes
  assign hit3 = (memAddr[31:24] == START_R3);
  assign reqAdv = hit0 ? adv0 : (hit1 ? adv1 : ADV_RST);
  assign curAdv = sel_q[0] ? adv0 : (sel_q[1] ? adv1 : ADV_RST);
  assign curBl = sel_q[0] ? bl0 : (sel_q[1] ? bl1 : BL_RST);

  // codes below the legal floor are raised to it
  assign trE = atLeast({1'b0, trQ}, TR_MIN);
  assign wpE = atLeast({1'b0, wpQ}, WP_MIN);
  assign ceoeE = atLeast({1'b0, ceoeQ}, CEOE_MIN);
  assign wcE = atLeast(wcQ, WC_MIN);
  assign rcE = atLeast(rcQ, RC_MIN);
  // strobe must end one clock before the cycle does
  assign weLim = (wpE < 4'(wcE - 4'h1)) ? wpE : 4'(wcE - 4'h2);

  assign timingWord = (32'(trQ) << TR_LSB) | (32'(wpQ) << WP_LSB)
    | (32'(ceoeQ) << CEOE_LSB) | (32'(wcQ) << WC_LSB)
    | (32'(rcQ) << RC_LSB);

  // bus engine
  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    write_d = write_q;
    beat_d = beat_q;
    phClear = 1'b0;
    memAck_d = 1'b0;
    memErr_d = 1'b0;
    memRdValid_d = 1'b0;
    memDone_d = 1'b0;
    memRdata_d = memRdata_q;
    applyNow = 1'b0;
    case (state_q)
      S_IDLE:
      begin
        // settings change only between accesses; the request waits
        if (pend_q != 3'h0)
          applyNow = 1'b1;
        else if (memReq && !memAck_q)
        begin
          memAck_d = 1'b1;
          // unconfigured space gets no bus cycle at all
          if (!(hit0 || hit1 || hit3))
            memErr_d = 1'b1;
          else
          begin
            sel_d = {hit3, hit1, hit0};
            addr_d = memAddr[23:1];
            wdata_d = memWdata;
            write_d = memWrite;
            beat_d = 2'h0;
            phClear = 1'b1;
            if (reqAdv)
              state_d = S_LATCH;
            else if (memWrite)
              state_d = S_WRITE;
            else
              state_d = S_READ;
          end
        end
      end
      S_LATCH:
      begin
        phClear = 1'b1;
        state_d = write_q ? S_WRITE : S_READ;
      end
      S_READ:
      begin
        if (phCount == 4'(rcE - 4'h1))
        begin
          memRdValid_d = 1'b1;
          memRdata_d = extDataIn;
          phClear = 1'b1;
          if (curBl == BL_FOUR && beat_q != BEAT_LAST)
          begin
            beat_d = beat_q + 2'h1;
            addr_d = addr_q + 23'h1;
          end
          else
          begin
            memDone_d = 1'b1;
            state_d = S_TURN;
          end
        end
      end
      S_WRITE:
      begin
        if (phCount == 4'(wcE - 4'h1))
        begin
          phClear = 1'b1;
          memDone_d = 1'b1;
          state_d = S_TURN;
        end
      end
      S_TURN:
      begin
        if (phCount == 4'(trE - 4'h1))
          state_d = S_IDLE;
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // pin decode from the next state, so the pins come straight off flops
  always_comb
  begin
    csZ_d = 1'b1;
    csO_d = 1'b1;
    csT_d = 1'b1;
    ale_d = (state_d == S_LATCH);
    oeN_d = 1'b1;
    weN_d = 1'b1;
    drvN_d = 1'b1;
    if (state_d == S_LATCH || state_d == S_READ || state_d == S_WRITE)
    begin
      csZ_d = !sel_d[0];
      csO_d = !sel_d[1];
      csT_d = !sel_d[2];
    end
    if (state_d == S_READ && phNext >= ceoeE)
      oeN_d = 1'b0;
    if (state_d == S_WRITE)
    begin
      drvN_d = 1'b0;
      if (phNext >= WE_START && phNext <= weLim)
        weN_d = 1'b0;
    end
  end

  // register file
  always_comb
  begin
    trD = trQ;
    wpD = wpQ;
    ceoeD = ceoeQ;
    wcD = wcQ;
    rcD = rcQ;
    setTim_d = setTim_q;
    setMode_d = setMode_q;
    pend_d = applyNow ? 3'h0 : pend_q;
    err_d = err_q;
    if (applyNow && pend_q[CMD_TIM_BIT])
    begin
      trD = setTim_q[TR_LSB +: 3];
      wpD = setTim_q[WP_LSB +: 3];
      ceoeD = setTim_q[CEOE_LSB +: 3];
      wcD = setTim_q[WC_LSB +: 4];
      rcD = setTim_q[RC_LSB +: 4];
    end
    if (regWrStb)
    begin
      case (regAddr)
        OFF_SET_TIMING: setTim_d = regWdata;
        OFF_SET_MODE: setMode_d = regWdata;
        OFF_CMD: pend_d = pend_d | regWdata[2:0];
        OFF_STATUS: err_d = err_q & !regWdata[ST_ERR_BIT];
        default: ;
      endcase
    end
    // a refused request in the clearing cycle still sets the flag
    if (memErr_d)
      err_d = 1'b1;
    regRdata_d = 32'h0;
    if (regRdStb)
    begin
      case (regAddr)
        OFF_TIMING3: regRdata_d = timingWord;
        OFF_MODE0: regRdata_d = mode0Word;
        OFF_MODE1: regRdata_d = mode1Word;
        OFF_SET_TIMING: regRdata_d = setTim_q;
        OFF_SET_MODE: regRdata_d = setMode_q;
        OFF_CMD: regRdata_d = 32'(pend_q);
        OFF_STATUS: regRdata_d = (32'(state_q != S_IDLE) << ST_BUSY_BIT)
          | (32'(err_q) << ST_ERR_BIT)
          | (32'(pend_q != 3'h0) << ST_PEND_BIT);
        default: regRdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      sel_q <= 3'h0;
      addr_q <= 23'h0;
      wdata_q <= 16'h0;
      write_q <= 1'b0;
      beat_q <= 2'h0;
      memAck_q <= 1'b0;
      memErr <= 1'b0;
      memRdValid <= 1'b0;
      memRdata_q <= 16'h0;
      memDone <= 1'b0;
      chipSelZeroN <= 1'b1;
      chipSelOneN <= 1'b1;
      chipSelThreeN <= 1'b1;
      addrLatch <= 1'b0;
      outEnN <= 1'b1;
      writeEnN <= 1'b1;
      extDataOeN <= 1'b1;
      extAddr <= 23'h0;
      extDataOut <= 16'h0;
      trQ <= TR_RST;
      wpQ <= WP_RST;
      ceoeQ <= CEOE_RST;
      wcQ <= WC_RST;
      rcQ <= RC_RST;
      setTim_q <= 32'h0;
      setMode_q <= 32'h0;
      pend_q <= 3'h0;
      err_q <= 1'b0;
      regRdata <= 32'h0;
      weRun_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      write_q <= write_d;
      beat_q <= beat_d;
      memAck_q <= memAck_d;
      memErr <= memErr_d;
      memRdValid <= memRdValid_d;
      memRdata_q <= memRdata_d;
      memDone <= memDone_d;
      chipSelZeroN <= csZ_d;
      chipSelOneN <= csO_d;
      chipSelThreeN <= csT_d;
      addrLatch <= ale_d;
      outEnN <= oeN_d;
      writeEnN <= weN_d;
      extDataOeN <= drvN_d;
      extAddr <= addr_d;
      extDataOut <= wdata_d;
      trQ <= trD;
      wpQ <= wpD;
      ceoeQ <= ceoeD;
      wcQ <= wcD;
      rcQ <= rcD;
      setTim_q <= setTim_d;
      setMode_q <= setMode_d;
      pend_q <= pend_d;
      err_q <= err_d;
      regRdata <= regRdata_d;
      weRun_q <= writeEnN ? 4'h0 : weRun_q + 4'h1;
    end
  end

  assign memAck = memAck_q;
  assign memRdata = memRdata_q;

  property p_turn_len;
    @(posedge clk) disable iff (reset)
    $fell(state_q == S_TURN) |-> $past(phCount) == 4'(trE - 4'h1);
  endproperty
  a_turn_len: assert property (p_turn_len)
    else $error("turnaround length");

  property p_we_width;
    @(posedge clk) disable iff (reset)
    $rose(writeEnN) |-> weRun_q == weLim;
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe width");

  property p_oe_delay;
    @(posedge clk) disable iff (reset)
    $fell(outEnN) |-> phCount == ceoeE && !chipSelZeroN + !chipSelOneN
      + !chipSelThreeN == 2'h1;
  endproperty
  a_oe_delay: assert property (p_oe_delay)
    else $error("read strobe delay");

  property p_wr_len;
    @(posedge clk) disable iff (reset)
    $rose(extDataOeN) |-> $past(phCount) == 4'(wcE - 4'h1) && memDone;
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("write cycle length");

  property p_rd_len;
    @(posedge clk) disable iff (reset)
    memRdValid |-> $past(phCount) == 4'(rcE - 4'h1) && $past(!outEnN);
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read cycle length");

  property p_mode0_start;
    @(posedge clk) disable iff (reset)
    regRdStb && regAddr == OFF_MODE0 |=> regRdata[31:24] == START_R0;
  endproperty
  a_mode0_start: assert property (p_mode0_start)
    else $error("region 0 start");

  property p_mode1_start;
    @(posedge clk) disable iff (reset)
    regRdStb && regAddr == OFF_MODE1 ##1 1'b1 |-> regRdata[31:24] == START_R1;
  endproperty
  a_mode1_start: assert property (p_mode1_start)
    else $error("region 1 start");

  property p_ale_use;
    @(posedge clk) disable iff (reset)
    addrLatch |-> curAdv ##1 !addrLatch;
  endproperty
  a_ale_use: assert property (p_ale_use)
    else $error("address latch use");

  property p_burst;
    @(posedge clk) disable iff (reset)
    memDone && !write_q |-> beat_q == ((curBl == BL_FOUR) ? BEAT_LAST : 2'h0);
  endproperty
  a_burst: assert property (p_burst)
    else $error("read burst beats");

  property p_one_select;
    @(posedge clk) disable iff (reset)
    state_q == S_IDLE && pend_q == 3'h0 && memReq && !memAck_q && hit0
      |=> !chipSelZeroN && chipSelOneN && chipSelThreeN;
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("chip select");

endmodule

// File: test/smctm_mem_model.sv
/*
  Behavioural asynchronous 16-bit static memory on the controller's pins.
  Assumes address and write data are held across the write strobe.
*/
`timescale 1ns/10ps
module smctm_mem_model
  #(parameter int DLY = 30)
(
  // strobes
  input wire logic selN,
  input wire logic outEnN,
  input wire logic writeEnN,
  // address and data
  input wire logic [22:0] extAddr,
  input wire logic [15:0] extDataOut,
  output logic [15:0] extDataIn
);
  logic [15:0] mem [0:255];
  logic [15:0] last = 16'h0000;
  logic drive;

  initial
  begin
    foreach (mem[i])
      mem[i] = 16'h0000;
  end

  assign drive = !selN && !outEnN;

  // slow access time, still inside one controller clock
  assign #DLY extDataIn = drive ? mem[extAddr[7:0]] : ~last;

  always @*
  begin
    if (drive)
      last = mem[extAddr[7:0]];
  end

  always @(posedge writeEnN)
  begin
    if (selN === 1'b0)
      mem[extAddr[7:0]] = extDataOut;
  end
endmodule

// File: test/smctm_top_tb.sv
/*
  Self-checking bench: register readback, pin timing of reads and writes,
  burst data and a refused address. Assumes the memory model on the pins.
*/
`timescale 1ns/10ps
module smctm_top_tb;
  import smctm_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic memReq = 1'b0;
  logic memWrite = 1'b0;
  logic [31:0] memAddr = 32'h0;
  logic [15:0] memWdata = 16'h0;
  logic [31:0] regRdata;
  logic memAck, memErr, memRdValid, memDone, addrLatch, outEnN;
  logic chipSelZeroN, chipSelOneN, chipSelThreeN, writeEnN, extDataOeN;
  logic [15:0] memRdata, extDataIn, extDataOut;
  logic [22:0] extAddr;
  int n_fail = 0;
  int compares = 0;
  int acc, ackWait, oeLow, weLow, latchCnt, nb, drvLow;
  int csLow [0:2];
  logic errSeen;
  logic [15:0] beats [0:3];
  logic [15:0] shadow [0:3];
  logic [7:0] regionByte [0:2] = '{8'h60, 8'h61, 8'h63};

  always #20 clk = ~clk;

  smctm_top u_smctm_top (.clk, .reset, .regAddr, .regWdata, .regWrStb,
    .regRdStb, .regRdata, .memReq, .memWrite, .memAddr, .memWdata,
    .memAck, .memErr, .memRdValid, .memRdata, .memDone, .chipSelZeroN,
    .chipSelOneN, .chipSelThreeN, .addrLatch, .outEnN, .writeEnN,
    .extAddr, .extDataIn, .extDataOut, .extDataOeN);

  smctm_mem_model #(.DLY(30)) u_smctm_mem_model (.outEnN, .writeEnN,
    .selN(chipSelZeroN & chipSelOneN & chipSelThreeN), .extAddr,
    .extDataOut, .extDataIn);

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] timWord(int tr, wp, ce, wc, rc);
    return (tr << TR_LSB) | (wp << WP_LSB) | (ce << CEOE_LSB) |
      (wc << WC_LSB) | rc;
  endfunction

  function automatic logic [31:0] modeWord(logic [7:0] s, int adv, bl, mw);
    return {s, 8'hff, 4'h0, 1'(adv), 5'h0, 3'(bl), 1'b0, 2'(mw)};
  endfunction

  function automatic int pick(int it, lo, hi);
    return it == 0 ? lo : it == 1 ? hi : lo + $urandom % (hi - lo + 1);
  endfunction

  // an idle cycle follows each strobe so no signal is assigned twice at once
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
  endtask

  task automatic regRd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask

  // entered at a clock edge; returns at the edge that saw memDone, or three edges after a refusal is seen
  task automatic access(input logic wr, input logic [31:0] a,
                        input logic [15:0] wd);
    memReq <= 1'b1;
    memWrite <= wr;
    memAddr <= a;
    memWdata <= wd;
    ackWait = 0;
    do
    begin
      @(posedge clk);
      ackWait++;
    end
    while (memAck !== 1'b1 && ackWait < 60);
    chk("request taken", 1, memAck);
    memReq <= 1'b0;
    errSeen = memErr;
    acc = 0;
    nb = 0;
    oeLow = 0;
    weLow = 0;
    latchCnt = 0;
    drvLow = 0;
    csLow = '{0, 0, 0};
    forever
    begin
      csLow[0] += !chipSelZeroN;
      csLow[1] += !chipSelOneN;
      csLow[2] += !chipSelThreeN;
      oeLow += !outEnN;
      weLow += !writeEnN;
      latchCnt += addrLatch;
      drvLow += !extDataOeN;
      if (memRdValid === 1'b1 && nb < 4)
      begin
        beats[nb] = memRdata;
        nb++;
      end
      if (memDone === 1'b1 || (errSeen === 1'b1 && acc == 3) || acc > 300)
        break;
      acc++;
      @(posedge clk);
    end
  endtask

  initial
  begin
    #(40 * 20000);
    n_fail++;
    $display("watchdog expired");
    conclude();
  end

  initial
  begin
    int tr, wp, ce, wc, rc, adv, bl, mw, k, sel;
    logic [31:0] base, rd, tw;
    void'($urandom(70567));
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    tw = timWord(1, 6, 3, 12, 4);
    regRd(OFF_TIMING3, rd);
    chk("timing3", tw, rd);
    regRd(OFF_MODE0, rd);
    chk("mode0", modeWord(8'h60, 1, 0, 1), rd);
    regRd(OFF_MODE1, rd);
    chk("mode1", modeWord(8'h61, 1, 0, 1), rd);
    regWr(OFF_TIMING3, 32'hffffffff);
    regRd(OFF_TIMING3, rd);
    chk("timing3", tw, rd);
    regRd(8'h40, rd);
    chk("unmapped", 32'h0, rd);
    $display("test reset values done");
    for (int it = 0; it < 6; it++)
    begin
      // let the last turnaround end so a new command applies at once
      repeat (8) @(posedge clk);
      tr = pick(it, 1, 7);
      wp = pick(it, 1, 7);
      wc = pick(it, 3, 15);
      rc = pick(it, 2, 15);
      ce = pick(it, 1, rc > 7 ? 7 : rc - 1);
      tw = timWord(tr, wp, ce, wc, rc);
      regWr(OFF_SET_TIMING, tw);
      regWr(OFF_CMD, 32'h1);
      regRd(OFF_TIMING3, rd);
      chk("timing3", tw, rd);
      adv = $urandom % 2;
      bl = $urandom % 2;
      mw = $urandom % 4;
      regWr(OFF_SET_MODE, modeWord(8'($urandom), adv, bl, mw));
      regWr(OFF_CMD, 32'h6);
      regRd(OFF_MODE0, rd);
      chk("mode0", modeWord(8'h60, adv, bl, mw), rd);
      regRd(OFF_MODE1, rd);
      chk("mode1", modeWord(8'h61, adv, bl, mw), rd);
      sel = it % 3;
      if (sel == 2)
      begin
        adv = 1;
        bl = 0;
      end
      base = {regionByte[sel], 16'h0, 8'($urandom) & 8'hf8};
      for (int w = 0; w < 4; w++)
      begin
        shadow[w] = 16'($urandom);
        access(1'b1, base + 32'(2 * w), shadow[w]);
        if (w > 0)
          chk("turnaround", tr + 1, ackWait);
        chk("write length", adv + wc, acc);
        chk("strobe width", wp < wc - 2 ? wp : wc - 2, weLow);
        chk("latch", adv, latchCnt);
        chk("data drive", wc, drvLow);
        chk("select", adv + wc, csLow[sel]);
      end
      k = bl == 1 ? 4 : 1;
      access(1'b0, base, 16'h0);
      chk("turnaround", tr + 1, ackWait);
      chk("read length", adv + rc * k, acc);
      chk("read delay", (rc - ce) * k, oeLow);
      chk("beats", k, nb);
      chk("read release", 0, drvLow);
      chk("other selects", 0,
        csLow[0] + csLow[1] + csLow[2] - csLow[sel]);
      for (int j = 0; j < k; j++)
        chk("read data", shadow[j], beats[j]);
      $display("test access pass %0d done", it);
    end
    access(1'b1, 32'h62000010, 16'h1234);
    chk("refused", 1, errSeen);
    chk("no select", 0, csLow[0] + csLow[1] + csLow[2]);
    regRd(OFF_STATUS, rd);
    chk("error flag", 32'h2, rd & 32'h2);
    regWr(OFF_STATUS, 32'h2);
    regRd(OFF_STATUS, rd);
    chk("error clear", 32'h0, rd & 32'h2);
    $display("test refused address done");
    conclude();
  end
endmodule
